// File: taxe_pkg.sv
/*
 * constants and types for the table access and xor execution slice.
 * assumes a single core clock in which four clocks make one instruction cycle.
 */
package taxe_pkg;

    localparam int          PTR_W        = 21;       // table pointer width
    localparam int          FADDR_W      = 12;       // bank and file address
    localparam int          HOLD_N       = 8;        // write holding registers
    localparam int          Q_PHASES     = 4;        // clocks per instruction cycle
    localparam logic [1:0]  Q2           = 2'h1;     // phase index of q2
    localparam logic [1:0]  Q3           = 2'h2;     // phase index of q3
    localparam logic [1:0]  Q4           = 2'h3;     // phase index of q4

    // pointer update encodings
    localparam logic [1:0]  UPD_NONE     = 2'h0;
    localparam logic [1:0]  UPD_POST_INC = 2'h1;
    localparam logic [1:0]  UPD_POST_DEC = 2'h2;
    localparam logic [1:0]  UPD_PRE_INC  = 2'h3;

    // access bank split: low half in bank 0, high half in the top bank
    localparam logic [7:0]  ACC_SPLIT    = 8'h80;
    localparam logic [3:0]  ACC_HI_BANK  = 4'hf;

    // status bit positions
    localparam int          ST_Z_BIT     = 2;
    localparam int          ST_N_BIT     = 4;

    // register byte offsets
    localparam logic [7:0]  OFF_PTR      = 8'h00;
    localparam logic [7:0]  OFF_LATCH    = 8'h04;
    localparam logic [7:0]  OFF_WREG     = 8'h08;
    localparam logic [7:0]  OFF_STATUS   = 8'h0c;
    localparam logic [7:0]  OFF_BANK     = 8'h10;
    localparam logic [7:0]  OFF_STATE    = 8'h14;
    localparam logic [7:0]  OFF_HOLD     = 8'h20;    // eight words up to 0x3c

    // reset values
    localparam logic [20:0] RST_PTR      = 21'h00_0000;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC1, ST_EXEC2, ST_NOP} taxe_st_type;
    typedef enum logic [2:0] {K_NONE, K_TRD, K_TWR, K_TST, K_XLW, K_XWF} taxe_kind_type;

    typedef struct packed {
        logic [1:0]               q;
        taxe_st_type              st;
        taxe_kind_type            kind;
        logic [15:0]              op;
        logic [1:0]               nopc;
        logic [7:0]               opnd;
        logic [7:0]               tmp;
        logic [FADDR_W-1:0]       faddr;
        logic [7:0]               fwd;
        logic [PTR_W-1:0]         ptr;
        logic [7:0]               latch;
        logic [7:0]               wreg;
        logic [7:0]               status;
        logic [3:0]               bank;
        logic [HOLD_N-1:0][7:0]   hold;
        logic                     aw_got;
        logic                     w_got;
        logic [7:0]               awaddr;
        logic [31:0]              wdata;
        logic [3:0]               wstrb;
        logic                     bvalid;
        logic [1:0]               bresp;
        logic                     rvalid;
        logic [1:0]               rresp;
        logic [31:0]              rdata;
    } taxe_state_type;

endpackage

// File: taxe_core.sv
/*
 * execution slice for table read, table write, test-skip-zero and xor.
 * assumes fetch offers one opcode at a time, program memory and the file
 * answer within the same clock, and software uses an axi4-lite master.
 */
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
// Functional notes
// - table read loads the addressed program byte into the latch, flags kept
// - table pointer is a 21-bit byte address over two megabytes
// - pointer bit zero picks low byte when 0, high byte when 1
// - table read opcode 0000 0000 0000 10nn, nn picks pointer update
// - table read takes two cycles, memory read q2, latch write q4
// - update choices: none, post-increment, post-decrement, pre-increment
// - table write copies latch into holding register picked by pointer bits 2:0
// - table write only loads holding registers, never program memory
// - table write has the same four updates and keeps flags
// - test-skip-zero opcode 0110 011a plus eight-bit register address
// - zero register discards the prefetched instruction, runs a nop, flags kept
// - test-skip takes one cycle, two on skip, three over two-word instruction
// - access selector zero forces access bank, one uses bank select
// - literal xor opcode 0000 1010 plus eight-bit immediate
// - literal xor writes working register and updates negative and zero
// - register xor opcode 0001 10da plus eight-bit register address
// - register xor in one cycle, updates negative and zero
// - destination zero writes working register, one writes file register
`timescale 1ns/1ns
module taxe_core (
    input  wire logic                           core_clk_i,       // 10 mhz core clock
    input  wire logic                           sys_rst_i,        // sync reset, high
    input  wire logic                           instr_valid_i,    // fetch offers opcode
    input  wire logic [15:0]                    instr_i,          // opcode word
    input  wire logic                           next_two_word_i,  // prefetched op is two words
    output logic                                instr_ready_o,    // opcode taken this clock
    output logic                                busy_o,           // instruction under way
    output logic                                flush_o,          // discard prefetched op
    output logic [taxe_pkg::PTR_W-2:0]          pmem_addr_o,      // program word address
    output logic                                pmem_rd_o,        // program read strobe
    input  wire logic [15:0]                    pmem_data_i,      // program word
    output logic [taxe_pkg::FADDR_W-1:0]        file_addr_o,      // file register address
    input  wire logic [7:0]                     file_rd_data_i,   // file read data
    output logic                                file_we_o,        // file write strobe
    output logic [7:0]                          file_wr_data_o,   // file write data
    input  wire logic                           s_axi_awvalid,    // write address valid
    output logic                                s_axi_awready,    // write address ready
    input  wire logic [7:0]                     s_axi_awaddr,     // write byte address
    input  wire logic                           s_axi_wvalid,     // write data valid
    output logic                                s_axi_wready,     // write data ready
    input  wire logic [31:0]                    s_axi_wdata,      // write data
    input  wire logic [3:0]                     s_axi_wstrb,      // byte enables
    output logic                                s_axi_bvalid,     // write response valid
    input  wire logic                           s_axi_bready,     // write response ready
    output logic [1:0]                          s_axi_bresp,      // write response
    input  wire logic                           s_axi_arvalid,    // read address valid
    output logic                                s_axi_arready,    // read address ready
    input  wire logic [7:0]                     s_axi_araddr,     // read byte address
    output logic                                s_axi_rvalid,     // read data valid
    input  wire logic                           s_axi_rready,     // read data ready
    output logic [31:0]                         s_axi_rdata,      // read data
    output logic [1:0]                          s_axi_rresp       // read response
);

    taxe_pkg::taxe_state_type s_ff;
    taxe_pkg::taxe_state_type nxt_s;

    // opcode classes
    function automatic taxe_pkg::taxe_kind_type decode(input logic [15:0] op);
        if (op[15:2] == 14'b0000_0000_0000_10) begin
            return taxe_pkg::K_TRD;
        end else if (op[15:2] == 14'b0000_0000_0000_11) begin
            return taxe_pkg::K_TWR;
        end else if (op[15:9] == 7'b0110_011) begin
            return taxe_pkg::K_TST;
        end else if (op[15:8] == 8'h0a) begin
            return taxe_pkg::K_XLW;
        end else if (op[15:10] == 6'b0001_10) begin
            return taxe_pkg::K_XWF;
        end
        return taxe_pkg::K_NONE;
    endfunction

    // pointer step; pre selects the step done before the access
    function automatic logic [20:0] ptr_step(input logic [20:0] p, input logic [1:0] m,
                                             input logic pre);
        if (pre && m == taxe_pkg::UPD_PRE_INC) begin
            return p + 21'h00_0001;
        end else if (!pre && m == taxe_pkg::UPD_POST_INC) begin
            return p + 21'h00_0001;
        end else if (!pre && m == taxe_pkg::UPD_POST_DEC) begin
            return p - 21'h00_0001;
        end
        return p;
    endfunction

    // n and z from an eight-bit result, other status bits kept
    function automatic logic [7:0] nz_flags(input logic [7:0] st, input logic [7:0] r);
        logic [7:0] f;
        f = st;
        f[taxe_pkg::ST_N_BIT] = r[7];
        f[taxe_pkg::ST_Z_BIT] = (r == 8'h00);
        return f;
    endfunction

    // byte-lane merge for bus writes
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] b);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (b[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    // accept only on q1 of an idle cycle
    assign instr_ready_o  = (s_ff.st == taxe_pkg::ST_IDLE) && (s_ff.q == 2'h0);
    assign busy_o         = (s_ff.st != taxe_pkg::ST_IDLE);
    assign pmem_addr_o    = s_ff.ptr[taxe_pkg::PTR_W-1:1];
    assign file_addr_o    = s_ff.faddr;
    assign file_wr_data_o = s_ff.fwd;
    // program memory is only ever read here; no write path exists
    assign pmem_rd_o      = (s_ff.st == taxe_pkg::ST_EXEC2) && (s_ff.kind == taxe_pkg::K_TRD)
                            && (s_ff.q == taxe_pkg::Q2);
    assign file_we_o      = (s_ff.st == taxe_pkg::ST_EXEC1) && (s_ff.kind == taxe_pkg::K_XWF)
                            && (s_ff.q == taxe_pkg::Q4) && s_ff.op[9];
    assign flush_o        = (s_ff.st == taxe_pkg::ST_EXEC1) && (s_ff.kind == taxe_pkg::K_TST)
                            && (s_ff.q == taxe_pkg::Q4) && (s_ff.opnd == 8'h00);
    assign s_axi_awready  = !s_ff.aw_got && !s_ff.bvalid;
    assign s_axi_wready   = !s_ff.w_got && !s_ff.bvalid;
    assign s_axi_bvalid   = s_ff.bvalid;
    assign s_axi_bresp    = s_ff.bresp;
    assign s_axi_arready  = !s_ff.rvalid;
    assign s_axi_rvalid   = s_ff.rvalid;
    assign s_axi_rdata    = s_ff.rdata;
    assign s_axi_rresp    = s_ff.rresp;

    // next state: bus writes first, so execution wins a same-clock clash
    always_comb begin
        logic [31:0] wv;
        logic [7:0]  res;
        wv    = 32'h0000_0000;
        res   = 8'h00;
        nxt_s = s_ff;
        nxt_s.q = s_ff.q + 2'h1;

        // write channels are taken independently, in either order
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_s.aw_got = 1'b1;
            nxt_s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_s.w_got = 1'b1;
            nxt_s.wdata = s_axi_wdata;
            nxt_s.wstrb = s_axi_wstrb;
        end
        if (s_ff.aw_got && s_ff.w_got) begin
            nxt_s.aw_got = 1'b0;
            nxt_s.w_got  = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp  = taxe_pkg::RESP_OKAY;
            wv = merge({11'h000, s_ff.ptr}, s_ff.wdata, s_ff.wstrb);
            unique case (s_ff.awaddr)
                taxe_pkg::OFF_PTR:    nxt_s.ptr    = wv[taxe_pkg::PTR_W-1:0];
                taxe_pkg::OFF_LATCH:  nxt_s.latch  = s_ff.wstrb[0] ? s_ff.wdata[7:0] : s_ff.latch;
                taxe_pkg::OFF_WREG:   nxt_s.wreg   = s_ff.wstrb[0] ? s_ff.wdata[7:0] : s_ff.wreg;
                taxe_pkg::OFF_STATUS: nxt_s.status = s_ff.wstrb[0] ? s_ff.wdata[7:0] : s_ff.status;
                taxe_pkg::OFF_BANK:   nxt_s.bank   = s_ff.wstrb[0] ? s_ff.wdata[3:0] : s_ff.bank;
                default:              nxt_s.bresp  = taxe_pkg::RESP_SLVERR;
            endcase
        end
        if (s_ff.bvalid && s_axi_bready) begin
            nxt_s.bvalid = 1'b0;
        end

        // read channel: one clock from address to data
        if (s_ff.rvalid && s_axi_rready) begin
            nxt_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_ff.rvalid) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp  = taxe_pkg::RESP_OKAY;
            nxt_s.rdata  = 32'h0000_0000;
            if (s_axi_araddr[7:5] == taxe_pkg::OFF_HOLD[7:5] && s_axi_araddr[1:0] == 2'h0) begin
                nxt_s.rdata[7:0] = s_ff.hold[s_axi_araddr[4:2]];
            end else begin
                unique case (s_axi_araddr)
                    taxe_pkg::OFF_PTR:    nxt_s.rdata[taxe_pkg::PTR_W-1:0] = s_ff.ptr;
                    taxe_pkg::OFF_LATCH:  nxt_s.rdata[7:0] = s_ff.latch;
                    taxe_pkg::OFF_WREG:   nxt_s.rdata[7:0] = s_ff.wreg;
                    taxe_pkg::OFF_STATUS: nxt_s.rdata[7:0] = s_ff.status;
                    taxe_pkg::OFF_BANK:   nxt_s.rdata[3:0] = s_ff.bank;
                    taxe_pkg::OFF_STATE:  nxt_s.rdata[2:0] = {s_ff.st, busy_o};
                    default:              nxt_s.rresp = taxe_pkg::RESP_SLVERR;
                endcase
            end
        end

        // instruction sequencing, one phase per clock
        unique case (s_ff.st)
            taxe_pkg::ST_IDLE: begin
                if (instr_ready_o && instr_valid_i) begin
                    nxt_s.op   = instr_i;
                    nxt_s.kind = decode(instr_i);
                    nxt_s.st   = taxe_pkg::ST_EXEC1;
                    if (!instr_i[8]) begin
                        nxt_s.faddr = {(instr_i[7:0] < taxe_pkg::ACC_SPLIT) ? 4'h0
                                       : taxe_pkg::ACC_HI_BANK, instr_i[7:0]};
                    end else begin
                        nxt_s.faddr = {s_ff.bank, instr_i[7:0]};
                    end
                end
            end
            taxe_pkg::ST_EXEC1: begin
                if (s_ff.q == taxe_pkg::Q2) begin
                    nxt_s.opnd = file_rd_data_i;
                end
                if (s_ff.q == taxe_pkg::Q3) begin
                    nxt_s.fwd = s_ff.wreg ^ s_ff.opnd;
                end
                if (s_ff.q == taxe_pkg::Q4) begin
                    nxt_s.st = taxe_pkg::ST_IDLE;
                    unique case (s_ff.kind)
                        taxe_pkg::K_XLW: begin
                            res = s_ff.wreg ^ s_ff.op[7:0];
                            nxt_s.wreg   = res;
                            nxt_s.status = nz_flags(s_ff.status, res);
                        end
                        taxe_pkg::K_XWF: begin
                            if (!s_ff.op[9]) begin
                                nxt_s.wreg = s_ff.fwd;
                            end
                            nxt_s.status = nz_flags(s_ff.status, s_ff.fwd);
                        end
                        taxe_pkg::K_TST: begin
                            // flags untouched; one or two nop cycles follow a skip
                            if (s_ff.opnd == 8'h00) begin
                                nxt_s.st   = taxe_pkg::ST_NOP;
                                nxt_s.nopc = next_two_word_i ? 2'h2 : 2'h1;
                            end
                        end
                        taxe_pkg::K_TRD, taxe_pkg::K_TWR: begin
                            nxt_s.ptr = ptr_step(s_ff.ptr, s_ff.op[1:0], 1'b1);
                            nxt_s.st  = taxe_pkg::ST_EXEC2;
                        end
                        default: ;
                    endcase
                end
            end
            taxe_pkg::ST_EXEC2: begin
                if (s_ff.q == taxe_pkg::Q2) begin
                    if (s_ff.kind == taxe_pkg::K_TRD) begin
                        nxt_s.tmp = s_ff.ptr[0] ? pmem_data_i[15:8] : pmem_data_i[7:0];
                    end else begin
                        nxt_s.tmp = s_ff.latch;
                    end
                end
                if (s_ff.q == taxe_pkg::Q4) begin
                    // no status writes here: table ops keep every flag
                    if (s_ff.kind == taxe_pkg::K_TRD) begin
                        nxt_s.latch = s_ff.tmp;
                    end else begin
                        nxt_s.hold[s_ff.ptr[2:0]] = s_ff.tmp;
                    end
                    nxt_s.ptr = ptr_step(s_ff.ptr, s_ff.op[1:0], 1'b0);
                    nxt_s.st  = taxe_pkg::ST_IDLE;
                end
            end
            taxe_pkg::ST_NOP: begin
                if (s_ff.q == taxe_pkg::Q4) begin
                    nxt_s.nopc = s_ff.nopc - 2'h1;
                    if (s_ff.nopc == 2'h1) begin
                        nxt_s.st = taxe_pkg::ST_IDLE;
                    end
                end
            end
        endcase
    end

    // single state register
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // checks on the execution timing and results
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_pmem_read_q2: assert property (pmem_rd_o |-> ##2 s_ff.q == taxe_pkg::Q4 ##1
        s_ff.latch == $past(s_ff.tmp))
        else $error("table latch not loaded two clocks after program read");
    a_ptr_post_inc: assert property ((s_ff.st == taxe_pkg::ST_EXEC2 && s_ff.q == taxe_pkg::Q4
        && s_ff.op[1:0] == taxe_pkg::UPD_POST_INC && !(s_ff.aw_got && s_ff.w_got))
        |=> s_ff.ptr == $past(s_ff.ptr) + 21'h00_0001)
        else $error("post-increment did not add one");
    a_hold_target: assert property ((s_ff.st == taxe_pkg::ST_EXEC2 && s_ff.q == taxe_pkg::Q4
        && s_ff.kind == taxe_pkg::K_TWR) |=>
        s_ff.hold[$past(s_ff.ptr[2:0])] == $past(s_ff.latch))
        else $error("holding register not loaded from latch");
    a_table_flags: assert property ((s_ff.st == taxe_pkg::ST_EXEC2
        && !(s_ff.aw_got && s_ff.w_got)) |=> $stable(s_ff.status))
        else $error("table operation changed status");
    a_skip_length: assert property ((flush_o && next_two_word_i) |=>
        (s_ff.st == taxe_pkg::ST_NOP)[*8])
        else $error("skip over two-word op shorter than two cycles");
    a_xor_literal: assert property ((s_ff.st == taxe_pkg::ST_EXEC1 && s_ff.q == taxe_pkg::Q4
        && s_ff.kind == taxe_pkg::K_XLW) |=>
        s_ff.wreg == ($past(s_ff.wreg) ^ $past(s_ff.op[7:0])))
        else $error("literal xor result wrong");
    // data is held against the file word seen at the read phase, not the internal copy
    a_file_write: assert property (file_we_o |-> s_ff.op[9] &&
        file_wr_data_o == (s_ff.wreg ^ $past(file_rd_data_i, 2)))
        else $error("file write without destination one or with wrong data");
    a_xor_file_flags: assert property ((s_ff.st == taxe_pkg::ST_EXEC1
        && s_ff.q == taxe_pkg::Q4 && s_ff.kind == taxe_pkg::K_XWF && !(s_ff.aw_got && s_ff.w_got))
        |=> s_ff.status[taxe_pkg::ST_N_BIT] == $past(s_ff.fwd[7])
        && s_ff.status[taxe_pkg::ST_Z_BIT] == ($past(s_ff.fwd) == 8'h00))
        else $error("register xor flags wrong");
    a_byte_select: assert property (pmem_rd_o |=> s_ff.tmp == ($past(s_ff.ptr[0])
        ? $past(pmem_data_i[15:8]) : $past(pmem_data_i[7:0])))
        else $error("wrong program byte captured");
    a_skip_short: assert property ((flush_o && !next_two_word_i) |=>
        (s_ff.st == taxe_pkg::ST_NOP)[*4] ##1 s_ff.st == taxe_pkg::ST_IDLE)
        else $error("single skip not one nop cycle");
    a_no_skip: assert property ((s_ff.st == taxe_pkg::ST_EXEC1 && s_ff.q == taxe_pkg::Q4
        && s_ff.kind == taxe_pkg::K_TST && s_ff.opnd != 8'h00) |=> s_ff.st == taxe_pkg::ST_IDLE)
        else $error("test-skip on nonzero did not end in one cycle");
    a_access_bank: assert property ((s_ff.st == taxe_pkg::ST_EXEC1 && !s_ff.op[8]
        && s_ff.op[7:0] < taxe_pkg::ACC_SPLIT) |-> file_addr_o[11:8] == 4'h0)
        else $error("access bank not forced");
    a_skip_flags: assert property ((s_ff.kind == taxe_pkg::K_TST && s_ff.st != taxe_pkg::ST_IDLE
        && !(s_ff.aw_got && s_ff.w_got)) |=> $stable(s_ff.status))
        else $error("test-skip changed status");

endmodule

// File: taxe_mem_model.sv
/*
 * behavioural program memory and data file behind the execution slice.
 * assumes one core clock; the program word is read combinationally.
 */
`timescale 1ns/1ns
module taxe_mem_model (
    input  wire logic        core_clk_i,     // core clock
    input  wire logic [19:0] pmem_addr_i,    // program word address
    input  wire logic        pmem_rd_i,      // program read strobe
    output logic [15:0]      pmem_data_o,    // program word
    input  wire logic [11:0] file_addr_i,    // file register address
    input  wire logic        file_we_i,      // file write strobe
    input  wire logic [7:0]  file_wr_data_i, // file write data
    output logic [7:0]       file_rd_data_o  // file read data
);
    logic [7:0] fmem [4096];
    // high byte is the inverse of the low byte, so a swapped half shows;
    // outside the strobe the word flips, so a stale sample is caught
    assign pmem_data_o = pmem_rd_i ? {~pmem_addr_i[7:0], pmem_addr_i[7:0]}
                                   : {pmem_addr_i[7:0], ~pmem_addr_i[7:0]};
    assign file_rd_data_o = fmem[file_addr_i];
    // writes land on the edge that samples the strobe
    always @(posedge core_clk_i) begin
        if (file_we_i) begin
            fmem[file_addr_i] <= file_wr_data_i;
        end
    end
    initial begin
        for (int i = 0; i < 4096; i++) begin
            fmem[i] = 8'h00;
        end
    end
endmodule

// File: taxe_core_bench.sv
/*
 * self-checking bench: axi4-lite register access plus opcode issue.
 * assumes the memory model beside the core and a single 10 mhz clock.
 */
`timescale 1ns/1ns
module taxe_core_bench;
    logic        core_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        instr_valid_i = 1'b0;
    logic        next_two_word_i = 1'b0;
    logic [15:0] instr_i = 16'h0000;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rd, rdata;
    logic [1:0]  rr, bresp, rresp;
    logic        rdy, busy, fl, prd, fwe, awr, wr_r, bv, arr, rv;
    logic [19:0] pa;
    logic [15:0] pd;
    logic [11:0] fa;
    logic [7:0]  fwd, frd;
    int          error_cnt = 0, n_checks = 0, n_fl = 0, n_rd = 0;
    taxe_core taxe_core_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i), .next_two_word_i(next_two_word_i),
        .instr_ready_o(rdy), .busy_o(busy), .flush_o(fl), .pmem_addr_o(pa), .pmem_rd_o(prd),
        .pmem_data_i(pd), .file_addr_o(fa), .file_rd_data_i(frd), .file_we_o(fwe),
        .file_wr_data_o(fwd), .s_axi_awvalid(awvalid), .s_axi_awready(awr),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wr_r), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arr), .s_axi_araddr(araddr),
        .s_axi_rvalid(rv), .s_axi_rready(1'b1), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
    taxe_mem_model taxe_mem_model_inst (.core_clk_i(core_clk_i), .pmem_addr_i(pa),
        .pmem_rd_i(prd), .pmem_data_o(pd), .file_addr_i(fa), .file_we_i(fwe),
        .file_wr_data_i(fwd), .file_rd_data_o(frd));
    always #50 core_clk_i = ~core_clk_i;
    // one-clock pulses are counted where they are sampled
    always @(posedge core_clk_i) begin
        if (fl === 1'b1) n_fl++;
        if (prd === 1'b1) n_rd++;
    end
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // address and data offered together, each dropped when taken
    task axw(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge core_clk_i);
            if (awvalid && awr) awvalid <= 1'b0;
            if (wvalid && wr_r) wvalid <= 1'b0;
        end while (bv !== 1'b1);
        rr = bresp;
    endtask
    task axr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge core_clk_i);
            if (arvalid && arr) arvalid <= 1'b0;
        end while (rv !== 1'b1);
        rd = rdata;
        rr = rresp;
    endtask
    task rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        axr(a);
        chk(nm, rd, exp);
    endtask
    // issue one opcode and count clocks until busy drops
    task run_op(input logic [15:0] op, input int ncyc);
        int n;
        instr_i <= op;
        instr_valid_i <= 1'b1;
        do @(posedge core_clk_i); while (rdy !== 1'b1);
        instr_valid_i <= 1'b0;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while ((busy !== 1'b0 || n == 1) && n < 20);
        chk("cycles", n, ncyc);
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk_i);
        error_cnt++;
        complete_run();
    end
    initial begin
        logic [20:0] p, a, np;
        repeat (4) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        rchk("ptr", taxe_pkg::OFF_PTR, 32'h0000_0000);
        axr(8'h40);
        chk("unmapped", {30'h0, rr}, {30'h0, taxe_pkg::RESP_SLVERR});
        axw(8'h40, 32'h0000_0000);
        chk("wresp", {30'h0, rr}, {30'h0, taxe_pkg::RESP_SLVERR});
        axw(taxe_pkg::OFF_STATUS, 32'h0000_0014);
        chk("wresp", {30'h0, rr}, {30'h0, taxe_pkg::RESP_OKAY});
        // all eight table opcodes from an odd pointer with low bits 111
        for (int k = 0; k < 8; k++) begin
            p = 21'h01_A357;
            a = (k[1:0] == 2'h3) ? p + 21'h1 : p;
            np = (k[1:0] == 2'h0) ? p : ((k[1:0] == 2'h2) ? p - 21'h1 : p + 21'h1);
            axw(taxe_pkg::OFF_PTR, {11'h0, p});
            axw(taxe_pkg::OFF_LATCH, 32'h40 + k);
            run_op({12'h000, 1'b1, k[2:0]}, 8);
            rchk("ptr", taxe_pkg::OFF_PTR, {11'h0, np});
            if (k < 4) rchk("latch", taxe_pkg::OFF_LATCH, {24'h0, a[0] ? ~a[8:1] : a[8:1]});
            else rchk("hold", taxe_pkg::OFF_HOLD + {a[2:0], 2'b00}, 32'h40 + k);
        end
        rchk("status", taxe_pkg::OFF_STATUS, 32'h0000_0014);
        chk("reads", n_rd, 4);
        $display("test table done");
        axw(taxe_pkg::OFF_WREG, 32'h0000_00B5);
        run_op(16'h0AAF, 4);
        rchk("wreg", taxe_pkg::OFF_WREG, 32'h0000_001A);
        run_op(16'h0A1A, 4);
        rchk("status", taxe_pkg::OFF_STATUS, 32'h0000_0004);
        $display("test literal done");
        taxe_mem_model_inst.fmem[12'h210] = 8'hAF;
        taxe_mem_model_inst.fmem[12'h010] = 8'h35;
        axw(taxe_pkg::OFF_BANK, 32'h0000_0002);
        axw(taxe_pkg::OFF_WREG, 32'h0000_00B5);
        run_op(16'h1B10, 4);
        chk("file", taxe_mem_model_inst.fmem[12'h210], 32'h0000_001A);
        rchk("wreg", taxe_pkg::OFF_WREG, 32'h0000_00B5);
        run_op(16'h1810, 4);
        rchk("wreg", taxe_pkg::OFF_WREG, 32'h0000_0080);
        rchk("status", taxe_pkg::OFF_STATUS, 32'h0000_0010);
        chk("file", taxe_mem_model_inst.fmem[12'h010], 32'h0000_0035);
        $display("test file done");
        taxe_mem_model_inst.fmem[12'h290] = 8'h05;
        taxe_mem_model_inst.fmem[12'hF90] = 8'h00;
        run_op(16'h6710, 4);
        chk("flush", n_fl, 0);
        run_op(16'h6690, 8);
        next_two_word_i <= 1'b1;
        run_op(16'h6690, 12);
        chk("flush", n_fl, 2);
        rchk("status", taxe_pkg::OFF_STATUS, 32'h0000_0010);
        $display("test skip done");
        complete_run();
    end
endmodule
